// ### rtl/mic_ctrl.sv
// interrupt controller top: apb registers, flags, gating, service and wake-up
`timescale 1ns/1ps

module mic_ctrl import mic_pkg::*; #(
    parameter int              PC_W     = 13,
    parameter logic [PC_W-1:0] VEC_BASE = 13'h0004,
    parameter logic [PC_W-1:0] VEC_STEP = 13'h0004
) (
    input  wire logic                pclk,
    input  wire logic                presetn,
    input  wire logic [7:0]          paddr,
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [31:0]         pwdata,
    output logic      [31:0]         prdata,
    output logic                     pready,
    output logic                     pslverr,
    input  wire logic [N_EXT-1:0]    ext_irq_pin,
    input  wire logic [N_EXT-1:0]    ext_pin_dir_in,
    input  wire logic                conv_done_evt,
    input  wire logic [N_SERIAL-1:0] serial_evt,
    input  wire logic [2*N_TMR-1:0]  tm_match_evt,
    input  wire logic                low_voltage_evt,
    input  wire logic                nvm_write_done_evt,
    input  wire logic                tick0_evt,
    input  wire logic                tick1_evt,
    input  wire logic                core_boundary,
    input  wire logic [PC_W-1:0]     core_pc_next,
    input  wire logic                stack_full,
    input  wire logic                return_from_irq_instr,
    input  wire logic [PC_W-1:0]     stack_top,
    output logic                     stack_push,
    output logic      [PC_W-1:0]     stack_push_data,
    output logic                     stack_pop,
    output logic                     pc_load,
    output logic      [PC_W-1:0]     pc_load_addr,
    output logic                     wake
);

    // ==========================================================
    // state
    logic [7:0]           edge_select_reg_q;
    logic [N_TOP-1:0]     tf_q;          // top-level request flags
    logic [N_TOP-1:0]     te_q;          // top-level enables
    logic                 global_irq_enable_q;
    logic [2*N_TMR-1:0]   tm_f_q;        // timer member flags, {A,P} per timer
    logic [2*N_TMR-1:0]   tm_e_q;
    logic [3:0]           m4_f_q;        // {tick1, tick0, nvm, low voltage}
    logic [3:0]           m4_e_q;
    logic [11:0]          mem_prev_q;
    logic [N_TOP-1:0]     tf_prev_q;
    logic [IDX_W-1:0]     svc_idx_q;
    logic                 pready_q, pslverr_q;
    logic [31:0]          prdata_q;
    logic                 stack_push_q, stack_pop_q, pc_load_q, wake_q;
    logic [PC_W-1:0]      push_data_q, load_addr_q;

    // ==========================================================
    // apb decode; one wait state so read data is registered
    logic       acc, wr, rd_done;
    logic [7:0] rd_byte;
    logic       hit;
    assign acc     = psel & penable & pready_q;
    assign wr      = acc & pwrite;
    assign rd_done = psel & penable & ~pready_q;

    logic w_edge, w_c0, w_c1, w_c2, w_g4;
    logic [N_TMR-1:0] w_tm;
    assign w_edge = wr && paddr == ADDR_EDGE;
    assign w_c0   = wr && paddr == ADDR_CTRL0;
    assign w_c1   = wr && paddr == ADDR_CTRL1;
    assign w_c2   = wr && paddr == ADDR_CTRL2;
    assign w_g4   = wr && paddr == ADDR_GRP4;

    // ==========================================================
    // event sources
    logic [N_EXT-1:0] ext_evt, ext_arm;
    // pin acts only when enabled and an input
    assign ext_arm = {te_q[IDX_EXT3], te_q[IDX_EXT2], te_q[IDX_EXT1], te_q[IDX_EXT0]} & ext_pin_dir_in;

    mic_edge_detect #(
        .N (N_EXT)
    ) u_edge (
        .pclk    (pclk),
        .presetn (presetn),
        .pin     (ext_irq_pin),
        .sel     (edge_select_reg_q),
        .arm     (ext_arm),
        .evt     (ext_evt)
    );

    // member rises feed both the group flags and the wake-up
    logic [11:0] mem_now, mem_rise;
    logic [4:0]  grp_set;
    assign mem_now  = {m4_f_q, tm_f_q};
    assign mem_rise = mem_now & ~mem_prev_q;
    // group set on any member rising
    for (genvar t = 0; t < N_TMR; t++) begin : g_grp
        assign grp_set[t] = |mem_rise[2*t+1:2*t];
    end
    assign grp_set[4] = |mem_rise[11:8];

    logic [N_TOP-1:0] tf_set;
    // hardware set terms, serial conditions ored
    assign tf_set = {grp_set[4], ext_evt[3:2], |serial_evt, conv_done_evt, grp_set[3:0], ext_evt[1:0]};

    // ==========================================================
    // arbitration and take decision
    logic [N_TOP-1:0] pend;
    logic             pv;
    logic [IDX_W-1:0] pidx;
    logic             take;
    logic [PC_W-1:0]  vec;
    assign pend = tf_q & te_q;

    mic_prio #(
        .N (N_TOP)
    ) u_prio (
        .req   (pend),
        .valid (pv),
        .idx   (pidx)
    );

    // global enable and stack room both required
    assign take = global_irq_enable_q & pv & ~stack_full & core_boundary & ~return_from_irq_instr;
    assign vec  = VEC_BASE + PC_W'(PC_W'(pidx) * VEC_STEP);

    // ==========================================================
    // edge select register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            edge_select_reg_q <= RST_BYTE;
        end else if (w_edge) begin
            edge_select_reg_q <= pwdata[7:0];
        end
    end

    // ==========================================================
    // top-level flags: service clear, then write, then set on top
    logic [N_TOP-1:0] sw_fm, sw_fv, svc_clr, tf_d;
    always_comb begin
        sw_fm = '0;
        sw_fv = '0;
        if (w_c0) begin
            sw_fm[2:0] = '1;
            sw_fv[2:0] = pwdata[6:4];
        end
        if (w_c1) begin
            sw_fm[6:3] = '1;
            sw_fv[6:3] = pwdata[7:4];
        end
        if (w_c2) begin
            sw_fm[10:7] = '1;
            sw_fv[10:7] = pwdata[7:4];
        end
        // only the served top flag is cleared
        svc_clr = '0;
        if (take) begin
            svc_clr[pidx] = 1'b1;
        end
        // flags latch regardless of global enable; set wins
        tf_d = ((sw_fm & sw_fv) | (~sw_fm & tf_q & ~svc_clr)) | tf_set;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tf_q <= '0;
        end else begin
            tf_q <= tf_d;
        end
    end

    // ==========================================================
    // top-level enables
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            te_q <= '0;
        end else begin
            if (w_c0) begin
                te_q[2:0] <= pwdata[3:1];
            end
            if (w_c1) begin
                te_q[6:3] <= pwdata[3:0];
            end
            if (w_c2) begin
                te_q[10:7] <= pwdata[3:0];
            end
        end
    end

    // ==========================================================
    // global enable; a software write in the take cycle wins,
    // since it is the later intent of the running program
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            global_irq_enable_q <= 1'b0;
        end else if (w_c0) begin
            global_irq_enable_q <= pwdata[0];
        end else if (take) begin
            global_irq_enable_q <= 1'b0;
        end
    end

    // ==========================================================
    // timer member registers, one per timer
    // members are never touched by service
    for (genvar t = 0; t < N_TMR; t++) begin : g_tm
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                tm_f_q[2*t+1:2*t] <= 2'h0;
                tm_e_q[2*t+1:2*t] <= 2'h0;
            end else begin
                if (w_tm[t]) begin
                    tm_f_q[2*t+1:2*t] <= pwdata[5:4] | tm_match_evt[2*t+1:2*t];
                    tm_e_q[2*t+1:2*t] <= pwdata[1:0];
                end else begin
                    tm_f_q[2*t+1:2*t] <= tm_f_q[2*t+1:2*t] | tm_match_evt[2*t+1:2*t];
                end
            end
        end
        assign w_tm[t] = wr && paddr == ADDR_GRP0 + 8'(t) * ADDR_STEP;
    end

    // ==========================================================
    // group four members: flags bits 7..4, enables bits 3..0
    logic [3:0] m4_set;
    assign m4_set = {tick1_evt, tick0_evt, nvm_write_done_evt, low_voltage_evt};
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            m4_f_q <= RST_BYTE[7:4];
            m4_e_q <= RST_BYTE[3:0];
        end else if (w_g4) begin
            m4_f_q <= pwdata[7:4] | m4_set;
            m4_e_q <= pwdata[3:0];
        end else begin
            m4_f_q <= m4_f_q | m4_set;
        end
    end

    // ==========================================================
    // history for rise detection of every flag
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mem_prev_q <= '0;
            tf_prev_q  <= '0;
        end else begin
            mem_prev_q <= mem_now;
            tf_prev_q  <= tf_q;
        end
    end

    // wake on any low-to-high, enables ignored
    // a flag preset before sleep cannot rise, so it stays quiet
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wake_q <= 1'b0;
        end else begin
            wake_q <= |mem_rise | |(tf_q & ~tf_prev_q);
        end
    end

    // ==========================================================
    // core side: push and vector, or pop on return
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stack_push_q <= 1'b0;
            stack_pop_q  <= 1'b0;
            pc_load_q    <= 1'b0;
            push_data_q  <= '0;
            load_addr_q  <= '0;
            svc_idx_q    <= '0;
        end else begin
            stack_push_q <= take;
            stack_pop_q  <= return_from_irq_instr;
            pc_load_q    <= take | return_from_irq_instr;
            if (return_from_irq_instr) begin
                load_addr_q <= stack_top;
            end else if (take) begin
                load_addr_q <= vec;
                push_data_q <= core_pc_next;
                svc_idx_q   <= pidx;
            end
        end
    end

    // ==========================================================
    // apb read mux; unmapped offsets answer with an error
    always_comb begin
        hit     = 1'b1;
        rd_byte = 8'h00;
        unique case (paddr)
            ADDR_EDGE:  rd_byte = edge_select_reg_q;
            ADDR_CTRL0: rd_byte = {1'b0, tf_q[2:0], te_q[2:0], global_irq_enable_q};
            ADDR_CTRL1: rd_byte = {tf_q[6:3], te_q[6:3]};
            ADDR_CTRL2: rd_byte = {tf_q[10:7], te_q[10:7]};
            8'h10:      rd_byte = {2'h0, tm_f_q[1:0], 2'h0, tm_e_q[1:0]};
            8'h14:      rd_byte = {2'h0, tm_f_q[3:2], 2'h0, tm_e_q[3:2]};
            8'h18:      rd_byte = {2'h0, tm_f_q[5:4], 2'h0, tm_e_q[5:4]};
            8'h1c:      rd_byte = {2'h0, tm_f_q[7:6], 2'h0, tm_e_q[7:6]};
            ADDR_GRP4:  rd_byte = {m4_f_q, m4_e_q};
            ADDR_STAT:  rd_byte = {pv, stack_full, 2'h0, svc_idx_q};
            default:    hit = 1'b0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= RST_WORD;
        end else begin
            pready_q  <= rd_done;
            pslverr_q <= rd_done & ~hit;
            if (rd_done && !pwrite) begin
                prdata_q <= {24'h0, rd_byte};
            end
        end
    end

    assign prdata          = prdata_q;
    assign pready          = pready_q;
    assign pslverr         = pslverr_q;
    assign stack_push      = stack_push_q;
    assign stack_push_data = push_data_q;
    assign stack_pop       = stack_pop_q;
    assign pc_load         = pc_load_q;
    assign pc_load_addr    = load_addr_q;
    assign wake            = wake_q;

    // ==========================================================
    // checks
    property p_conv_set;
        @(posedge pclk) disable iff (!presetn) conv_done_evt |=> tf_q[IDX_CONV];
    endproperty
    a_conv_set: assert property (p_conv_set) else $error("conversion flag not set");

    property p_gate;
        @(posedge pclk) disable iff (!presetn) !global_irq_enable_q |=> !stack_push_q;
    endproperty
    a_gate: assert property (p_gate) else $error("service while globally disabled");

    property p_enabled;
        @(posedge pclk) disable iff (!presetn) take |-> te_q[pidx] && tf_q[pidx];
    endproperty
    a_enabled: assert property (p_enabled) else $error("disabled source serviced");

    property p_push;
        @(posedge pclk) disable iff (!presetn)
            take |=> stack_push_q && pc_load_q && pc_load_addr == $past(vec) && stack_push_data == $past(core_pc_next);
    endproperty
    a_push: assert property (p_push) else $error("push or vector wrong");

    property p_ret;
        @(posedge pclk) disable iff (!presetn)
            return_from_irq_instr |=> stack_pop_q && pc_load_q && !stack_push_q && pc_load_addr == $past(stack_top);
    endproperty
    a_ret: assert property (p_ret) else $error("return did not pop");

    property p_gie_clr;
        @(posedge pclk) disable iff (!presetn) take && !w_c0 |=> !global_irq_enable_q;
    endproperty
    a_gie_clr: assert property (p_gie_clr) else $error("global enable kept");

    property p_stack;
        @(posedge pclk) disable iff (!presetn) stack_full |=> !stack_push_q;
    endproperty
    a_stack: assert property (p_stack) else $error("push with full stack");

    property p_wake;
        @(posedge pclk) disable iff (!presetn) conv_done_evt && !tf_q[IDX_CONV] |=> ##1 wake_q;
    endproperty
    a_wake: assert property (p_wake) else $error("no wake on flag rise");

    property p_grp;
        @(posedge pclk) disable iff (!presetn) tm_match_evt[0] && !tm_f_q[0] |=> tm_f_q[0] ##1 tf_q[IDX_GRP0];
    endproperty
    a_grp: assert property (p_grp) else $error("group flag not set");

endmodule

// ### rtl/mic_edge_detect.sv
// external pin synchronisers and selectable edge detection
`timescale 1ns/1ps

module mic_edge_detect import mic_pkg::*; #(
    parameter int N = 4
) (
    input  wire logic           pclk,
    input  wire logic           presetn,
    input  wire logic [N-1:0]   pin,
    input  wire logic [2*N-1:0] sel,
    input  wire logic [N-1:0]   arm,
    output logic      [N-1:0]   evt
);

    // ==========================================================
    // per pin: two-stage sync, then a history flop for edges
    for (genvar i = 0; i < N; i++) begin : g_pin
        logic s1_q, s2_q, prev_q;
        logic [1:0] mode;
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                s1_q   <= 1'b0;
                s2_q   <= 1'b0;
                prev_q <= 1'b0;
            end else begin
                s1_q   <= pin[i];
                s2_q   <= s1_q;
                prev_q <= s2_q;
            end
        end
        assign mode = sel[2*i+1:2*i];
        always_comb begin
            unique case (mode)
                EDGE_OFF:  evt[i] = 1'b0;
                EDGE_RISE: evt[i] = arm[i] & s2_q & ~prev_q;
                EDGE_FALL: evt[i] = arm[i] & ~s2_q & prev_q;
                EDGE_BOTH: evt[i] = arm[i] & (s2_q ^ prev_q);
            endcase
        end
    end

endmodule

// ### rtl/mic_pkg.sv
// shared constants of the interrupt controller: register map, indices, reset values
package mic_pkg;

    // ==========================================================
    // register byte offsets on the apb bus
    localparam logic [7:0] ADDR_EDGE  = 8'h00;  // edge_select_reg
    localparam logic [7:0] ADDR_CTRL0 = 8'h04;  // ext0/ext1/group0 flags, enables, global enable
    localparam logic [7:0] ADDR_CTRL1 = 8'h08;  // conversion, group1..3
    localparam logic [7:0] ADDR_CTRL2 = 8'h0c;  // serial, ext2/ext3, group4
    localparam logic [7:0] ADDR_GRP0  = 8'h10;  // timer member registers 0..3, one word apart
    localparam logic [7:0] ADDR_GRP4  = 8'h20;  // timebase_eeprom_lvd_irq_ctrl
    localparam logic [7:0] ADDR_STAT  = 8'h24;  // read-only service status
    localparam logic [7:0] ADDR_STEP  = 8'h04;

    // ==========================================================
    // reset values
    localparam logic [7:0] RST_BYTE   = 8'h00;
    localparam logic [31:0] RST_WORD  = 32'h0000_0000;

    // ==========================================================
    // source counts and fixed service order, lowest index first
    localparam int N_EXT    = 4;
    localparam int N_TMR    = 4;
    localparam int N_TOP    = 11;
    localparam int N_SERIAL = 6;
    localparam int IDX_W    = 4;
    localparam int IDX_EXT0 = 0;
    localparam int IDX_EXT1 = 1;
    localparam int IDX_GRP0 = 2;
    localparam int IDX_CONV = 6;
    localparam int IDX_SER  = 7;
    localparam int IDX_EXT2 = 8;
    localparam int IDX_EXT3 = 9;
    localparam int IDX_GRP4 = 10;

    // ==========================================================
    // edge select encodings
    localparam logic [1:0] EDGE_OFF  = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_FALL = 2'h2;
    localparam logic [1:0] EDGE_BOTH = 2'h3;

endpackage

// ### rtl/mic_prio.sv
// fixed priority pick: lowest index of the pending set wins
`timescale 1ns/1ps

module mic_prio import mic_pkg::*; #(
    parameter int N = N_TOP
) (
    input  wire logic [N-1:0]     req,
    output logic                  valid,
    output logic      [IDX_W-1:0] idx
);

    // ==========================================================
    // scan from the top down so the lowest index is left standing
    // fixed service order
    always_comb begin
        valid = |req;
        idx   = '0;
        for (int i = N - 1; i >= 0; i--) begin
            if (req[i]) begin
                idx = IDX_W'(i);
            end
        end
    end

endmodule

// ### verif/mic_core_model.sv
// core sequencer and return stack model facing the controller
`timescale 1ns/1ps

module mic_core_model #(
    parameter int DEPTH = 2
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        ret_req,
    input  wire logic        stack_push,
    input  wire logic [12:0] stack_push_data,
    input  wire logic        stack_pop,
    output logic             core_boundary,
    output logic      [12:0] core_pc_next,
    output logic             stack_full,
    output logic             return_from_irq_instr,
    output logic      [12:0] stack_top
);
    // ====================
    // stack and sequencer
    logic [12:0] stk_q [DEPTH];
    int          sp_q;

    // shallow stack so the full case is reached quickly
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sp_q <= 0;
        end else if (stack_push && sp_q < DEPTH) begin
            stk_q[sp_q] <= stack_push_data;
            sp_q        <= sp_q + 1;
        end else if (stack_pop && sp_q > 0) begin
            sp_q <= sp_q - 1;
        end
    end
    assign stack_full = (sp_q == DEPTH);
    // empty stack shows a moving pattern, never a stale address
    assign stack_top  = (sp_q > 0) ? stk_q[sp_q-1] : ~core_pc_next;

    // boundary only every other cycle, like a slow instruction stream
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            core_pc_next          <= 13'h0100;
            core_boundary         <= 1'b0;
            return_from_irq_instr <= 1'b0;
        end else begin
            core_pc_next          <= core_pc_next + 13'h0001;
            core_boundary         <= ~core_boundary;
            return_from_irq_instr <= ret_req & ~return_from_irq_instr;
        end
    end
endmodule

// ### verif/tb_mic_ctrl.sv
// self-checking bench of the interrupt controller
`timescale 1ns/1ps

module tb_mic_ctrl import mic_pkg::*;;
    // ====================
    // signals and instances
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, ret_req = 1'b0;
    logic [7:0]  paddr = 8'h00, tm_match_evt = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, stack_push, stack_pop, pc_load, wake, serr, core_boundary, stack_full;
    logic        conv_done_evt = 1'b0, low_voltage_evt = 1'b0, nvm_write_done_evt = 1'b0, return_from_irq_instr;
    logic        tick0_evt = 1'b0, tick1_evt = 1'b0;
    logic [3:0]  ext_irq_pin = 4'h0, ext_pin_dir_in = 4'h0, r4;
    logic [5:0]  serial_evt = 6'h00;
    logic [12:0] core_pc_next, stack_top, stack_push_data, pc_load_addr, vec = 13'h0, pushed = 13'h0;
    int          err_count = 0, total_checks = 0, loads = 0, wakes = 0, pops = 0, w0;

    mic_ctrl i_mic_ctrl (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
        .pslverr, .ext_irq_pin, .ext_pin_dir_in, .conv_done_evt, .serial_evt, .tm_match_evt, .low_voltage_evt,
        .nvm_write_done_evt, .tick0_evt, .tick1_evt, .core_boundary, .core_pc_next, .stack_full,
        .return_from_irq_instr, .stack_top, .stack_push, .stack_push_data, .stack_pop, .pc_load,
        .pc_load_addr, .wake);
    mic_core_model i_mic_core_model (.pclk, .presetn, .ret_req, .stack_push, .stack_push_data, .stack_pop,
        .core_boundary, .core_pc_next, .stack_full, .return_from_irq_instr, .stack_top);

    initial begin
        forever #12.5 pclk = ~pclk;
    end

    // what the core sees: vectors, pushed addresses, wake pulses
    always @(posedge pclk) begin
        if (pc_load === 1'b1) begin
            loads <= loads + 1;
            vec   <= pc_load_addr;
        end
        if (stack_push === 1'b1) pushed <= stack_push_data;
        if (stack_pop === 1'b1) pops <= pops + 1;
        if (wake === 1'b1) wakes <= wakes + 1;
    end

    function automatic logic [12:0] vexp(input int i);
        return 13'h0004 + 13'(i) * 13'h0004;
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask
    // upper data bits random: the slave must ignore them
    task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
        int n;
        n = 0;
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= ($urandom() & 32'hffff_ff00) | {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        // a slave that never answers is a failure, not a silent skip
        if (pready !== 1'b1) err_count++;
        rd      = prdata;
        serr    = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        apb(1'b0, a, 8'h00);
        chk(rd, {24'h0, e});
    endtask
    task automatic ret();
        ret_req <= 1'b1;
        @(posedge pclk);
        ret_req <= 1'b0;
        cyc(6);
    endtask
    task automatic fire(input logic c, input logic [5:0] s, input logic [3:0] g);
        conv_done_evt <= c;
        serial_evt    <= s;
        {tick1_evt, tick0_evt, nvm_write_done_evt, low_voltage_evt} <= g;
        @(posedge pclk);
        conv_done_evt <= 1'b0;
        serial_evt    <= 6'h00;
        {tick1_evt, tick0_evt, nvm_write_done_evt, low_voltage_evt} <= 4'h0;
        cyc(6);
    endtask
    task automatic end_sim();
        $display("checks=%0d errors=%0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // hang guard, far beyond the few hundred cycles needed
    initial begin
        #1000000;
        err_count++;
        end_sim();
    end

    initial begin
        void'($urandom(32'h81d4));
        cyc(4);
        presetn <= 1'b1;
        cyc(1);
        rdc(ADDR_GRP4, 8'h00);
        apb(1'b0, 8'h28, 8'h00);
        chk({31'h0, serr}, 32'h1);
        r4 = 4'($urandom());
        wr(ADDR_GRP4, {r4, ~r4});
        rdc(ADDR_GRP4, {r4, ~r4});
        wr(ADDR_GRP4, 8'h00);
        wr(ADDR_CTRL2, 8'h00);
        wr(ADDR_CTRL0, 8'h01);
        w0 = wakes;
        fire(1'b1, 6'h00, 4'h0);
        rdc(ADDR_CTRL1, 8'h80);
        chk(loads, 0);
        fire(1'b1, 6'h00, 4'h0);
        chk(wakes - w0, 1);
        wr(ADDR_CTRL1, 8'h88);
        cyc(6);
        chk(vec, vexp(IDX_CONV));
        rdc(ADDR_CTRL1, 8'h08);
        rdc(ADDR_CTRL0, 8'h00);
        fire(1'b1, 6'h00, 4'h0);
        chk(loads, 1);
        rdc(ADDR_CTRL1, 8'h88);
        ret();
        chk(vec, pushed);
        chk(pops, 1);
        wr(ADDR_CTRL0, 8'h01);
        cyc(6);
        chk(loads, 3);
        // second service fills the two-deep stack, third must wait
        wr(ADDR_CTRL0, 8'h01);
        fire(1'b1, 6'h00, 4'h0);
        wr(ADDR_CTRL0, 8'h01);
        fire(1'b1, 6'h00, 4'h0);
        chk(loads, 4);
        ret();
        chk(loads, 6);
        ret();
        ret();
        r4 = 4'($urandom()) | 4'h8;
        wr(ADDR_GRP4, 8'h08);
        wr(ADDR_CTRL2, 8'h08);
        wr(ADDR_CTRL0, 8'h01);
        fire(1'b0, 6'h00, r4);
        chk(vec, vexp(IDX_GRP4));
        rdc(ADDR_GRP4, {r4, 4'h8});
        rdc(ADDR_CTRL2, 8'h08);
        wr(ADDR_GRP4, 8'h00);
        ret();
        wr(ADDR_CTRL2, 8'h01);
        fire(1'b1, 6'h01, 4'h0);
        wr(ADDR_CTRL0, 8'h01);
        cyc(6);
        chk(vec, vexp(IDX_CONV));
        ret();
        wr(ADDR_CTRL0, 8'h01);
        cyc(6);
        chk(vec, vexp(IDX_SER));
        rdc(ADDR_CTRL2, 8'h01);
        ret();
        for (int i = 0; i < N_SERIAL; i++) begin
            fire(1'b0, 6'(6'h01 << i), 4'h0);
            rdc(ADDR_CTRL2, 8'h11);
            wr(ADDR_CTRL2, 8'h01);
        end
        ext_pin_dir_in <= 4'hf;
        wr(ADDR_CTRL0, 8'h02);
        for (int c = 0; c < 4; c++) begin
            wr(ADDR_EDGE, 8'(c));
            ext_irq_pin[0] <= 1'b1;
            cyc(6);
            rdc(ADDR_CTRL0, {3'h0, c[0], 4'h2});
            wr(ADDR_CTRL0, 8'h02);
            ext_irq_pin[0] <= 1'b0;
            cyc(6);
            rdc(ADDR_CTRL0, {3'h0, c[1], 4'h2});
            wr(ADDR_CTRL0, 8'h02);
        end
        ext_pin_dir_in <= 4'he;
        ext_irq_pin[0] <= 1'b1;
        cyc(6);
        rdc(ADDR_CTRL0, 8'h02);
        ext_pin_dir_in <= 4'hf;
        wr(ADDR_CTRL0, 8'h03);
        ext_irq_pin[0] <= 1'b0;
        cyc(8);
        chk(vec, vexp(IDX_EXT0));
        rdc(ADDR_CTRL0, 8'h02);
        // timer member feeds group zero; member flag survives service
        tm_match_evt <= 8'h01;
        @(posedge pclk);
        tm_match_evt <= 8'h00;
        cyc(4);
        rdc(ADDR_CTRL0, 8'h42);
        wr(ADDR_CTRL0, 8'h4b);
        cyc(6);
        chk(vec, vexp(IDX_GRP0));
        rdc(ADDR_CTRL0, 8'h0a);
        rdc(ADDR_GRP0, 8'h10);
        end_sim();
    end
endmodule
